// file: acc_pkg.sv
// Constants, types and the contract summary for the calibration coefficient bank
// Contract
// - Offset and gain coefficients are 24 bits, readable and writable at any time
// - Offset is two's complement over high, middle and low byte registers
// - 24-bit variant offset LSB weighs 1; 16-bit variant has eight fractional bits
// - Offset calibration at full-scale positive or negative raises the converter error
// - Gain is unsigned fixed point, top bit weighs one, range below two
// - Gain calibration yielding zero or all ones raises the converter error
// - Conversion results get offset subtracted, then multiplied by gain
// - A finished calibration writes its coefficient into the matching register group
// - Out-of-limit calibration results show on the general converter error flag
package acc_pkg;
  localparam int unsigned COEF_W = 24;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned GAIN_FRAC = 23;

  // Special function register addresses
  localparam logic [7:0] ADDR_OFFSET_HIGH   = 8'hC0;
  localparam logic [7:0] ADDR_OFFSET_MIDDLE = 8'hC1;
  localparam logic [7:0] ADDR_OFFSET_LOW    = 8'hC2;
  localparam logic [7:0] ADDR_GAIN_HIGH     = 8'hC3;
  localparam logic [7:0] ADDR_GAIN_MIDDLE   = 8'hC4;
  localparam logic [7:0] ADDR_GAIN_LOW      = 8'hC5;

  localparam logic [23:0] OFFSET_RESET = 24'h000000;
  localparam logic [23:0] GAIN_RESET   = 24'h800000;

  localparam logic [23:0] OFFSET_FS_POS = 24'h7FFFFF;
  localparam logic [23:0] OFFSET_FS_NEG = 24'h800000;
  localparam logic [23:0] GAIN_MIN      = 24'h000000;
  localparam logic [23:0] GAIN_MAX      = 24'hFFFFFF;

  localparam logic [23:0] RESULT_MAX = 24'h7FFFFF;
  localparam logic [23:0] RESULT_MIN = 24'h800000;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } acc_sfr_req_t;

  typedef struct packed {
    logic        done;
    logic        is_gain;
    logic [23:0] value;
  } acc_cal_result_t;
endpackage

// file: acc_bank.sv
// Calibration coefficient registers, error detection and result correction
`timescale 1ns/100ps
module acc_bank #(
  parameter bit RES16 = 1'b0
) (
  input  wire logic                     clk_in,
  input  wire logic                     resetn_in,
  input  wire acc_pkg::acc_sfr_req_t    sfr_req_in,
  output logic [7:0]                    sfr_rdata_out,
  input  wire acc_pkg::acc_cal_result_t cal_result_in,
  input  wire logic                     err_clear_in,
  output logic                          converter_error_flag_out,
  input  wire logic                     conv_valid_in,
  input  wire logic [23:0]              conv_data_in,
  output logic                          conv_valid_out,
  output logic [23:0]                   conv_data_out
);

  logic [23:0] offset_coef;
  logic [23:0] gain_coef;
  logic [23:0] next_offset_coef;
  logic [23:0] next_gain_coef;
  logic [7:0]  next_sfr_rdata;
  logic        next_error;
  logic        cal_bad;

  // Replace one byte lane of a coefficient
  function automatic logic [23:0] put_byte(input logic [23:0] v, input logic [1:0] lane,
                                           input logic [7:0] b);
    logic [23:0] r;
    r = v;
    case (lane)
      2'd2: r[23:16] = b;
      2'd1: r[15:8]  = b;
      default: r[7:0] = b;
    endcase
    return r;
  endfunction

  // Limit check on a freshly measured coefficient
  function automatic logic coef_extreme(input logic is_gain, input logic [23:0] v);
    if (is_gain) begin
      return (v == acc_pkg::GAIN_MIN) || (v == acc_pkg::GAIN_MAX);
    end
    return (v == acc_pkg::OFFSET_FS_POS) || (v == acc_pkg::OFFSET_FS_NEG);
  endfunction

  assign cal_bad = cal_result_in.done && coef_extreme(cal_result_in.is_gain, cal_result_in.value);

  // Register writes; a finished calibration overrides a software write to the same coefficient in the same cycle
  always_comb begin
    next_offset_coef = offset_coef;
    next_gain_coef   = gain_coef;
    if (sfr_req_in.wr) begin
      case (sfr_req_in.addr)
        acc_pkg::ADDR_OFFSET_HIGH:   next_offset_coef = put_byte(offset_coef, 2'd2,
                                                                 sfr_req_in.wdata);
        acc_pkg::ADDR_OFFSET_MIDDLE: next_offset_coef = put_byte(offset_coef, 2'd1,
                                                                 sfr_req_in.wdata);
        acc_pkg::ADDR_OFFSET_LOW:    next_offset_coef = put_byte(offset_coef, 2'd0,
                                                                 sfr_req_in.wdata);
        acc_pkg::ADDR_GAIN_HIGH:     next_gain_coef = put_byte(gain_coef, 2'd2,
                                                               sfr_req_in.wdata);
        acc_pkg::ADDR_GAIN_MIDDLE:   next_gain_coef = put_byte(gain_coef, 2'd1,
                                                               sfr_req_in.wdata);
        acc_pkg::ADDR_GAIN_LOW:      next_gain_coef = put_byte(gain_coef, 2'd0,
                                                               sfr_req_in.wdata);
        default: ;
      endcase
    end
    if (cal_result_in.done) begin
      if (cal_result_in.is_gain) begin
        next_gain_coef = cal_result_in.value;
      end else begin
        next_offset_coef = cal_result_in.value;
      end
    end
  end

  // Read data is registered; unmapped addresses read as zero
  always_comb begin
    next_sfr_rdata = sfr_rdata_out;
    if (sfr_req_in.rd) begin
      case (sfr_req_in.addr)
        acc_pkg::ADDR_OFFSET_HIGH:   next_sfr_rdata = offset_coef[23:16];
        acc_pkg::ADDR_OFFSET_MIDDLE: next_sfr_rdata = offset_coef[15:8];
        acc_pkg::ADDR_OFFSET_LOW:    next_sfr_rdata = offset_coef[7:0];
        acc_pkg::ADDR_GAIN_HIGH:     next_sfr_rdata = gain_coef[23:16];
        acc_pkg::ADDR_GAIN_MIDDLE:   next_sfr_rdata = gain_coef[15:8];
        acc_pkg::ADDR_GAIN_LOW:      next_sfr_rdata = gain_coef[7:0];
        default:                     next_sfr_rdata = 8'h00;
      endcase
    end
  end

  // Sticky error; a new bad result wins over a clear in the same cycle
  always_comb begin
    next_error = converter_error_flag_out;
    if (err_clear_in) begin
      next_error = 1'b0;
    end
    if (cal_bad) begin
      next_error = 1'b1;
    end
  end

  // Correction arithmetic. On the 16-bit variant the result sits in bits 23:8,
  // so the offset's low byte lines up as the fraction below its LSB.
  logic signed [24:0] diff;
  logic signed [49:0] product;
  logic signed [26:0] scaled;
  logic [23:0]        next_conv_data;

  always_comb begin
    diff    = $signed({conv_data_in[23], conv_data_in}) -
              $signed({offset_coef[23], offset_coef});
    product = diff * $signed({1'b0, gain_coef});
    scaled  = product[49:23];
    if (scaled > $signed({{3{1'b0}}, acc_pkg::RESULT_MAX})) begin
      next_conv_data = acc_pkg::RESULT_MAX;
    end else if (scaled < $signed({{3{1'b1}}, acc_pkg::RESULT_MIN})) begin
      next_conv_data = acc_pkg::RESULT_MIN;
    end else begin
      next_conv_data = scaled[23:0];
    end
    if (RES16) begin
      next_conv_data[7:0] = 8'h00;
    end
    // Between results the last corrected word stays on the output
    if (!conv_valid_in) begin
      next_conv_data = conv_data_out;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      offset_coef              <= acc_pkg::OFFSET_RESET;
      gain_coef                <= acc_pkg::GAIN_RESET;
      sfr_rdata_out            <= 8'h00;
      converter_error_flag_out <= 1'b0;
      conv_valid_out           <= 1'b0;
      conv_data_out            <= 24'h000000;
    end else begin
      offset_coef              <= next_offset_coef;
      gain_coef                <= next_gain_coef;
      sfr_rdata_out            <= next_sfr_rdata;
      converter_error_flag_out <= next_error;
      conv_valid_out           <= conv_valid_in;
      conv_data_out            <= next_conv_data;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  offset_cal_store_a: assert property (
    cal_result_in.done && !cal_result_in.is_gain |=> offset_coef == $past(cal_result_in.value))
    else $error("offset calibration result not stored");
  gain_cal_store_a: assert property (
    cal_result_in.done && cal_result_in.is_gain |=> gain_coef == $past(cal_result_in.value))
    else $error("gain calibration result not stored");
  offset_hi_write_a: assert property (
    sfr_req_in.wr && sfr_req_in.addr == acc_pkg::ADDR_OFFSET_HIGH && !cal_result_in.done
    |=> offset_coef[23:16] == $past(sfr_req_in.wdata) && $stable(offset_coef[15:0]))
    else $error("offset high byte write wrong");
  gain_lo_write_a: assert property (
    sfr_req_in.wr && sfr_req_in.addr == acc_pkg::ADDR_GAIN_LOW && !cal_result_in.done
    |=> gain_coef[7:0] == $past(sfr_req_in.wdata) && $stable(gain_coef[23:8]))
    else $error("gain low byte write wrong");
  readback_mid_a: assert property (
    sfr_req_in.rd && sfr_req_in.addr == acc_pkg::ADDR_OFFSET_MIDDLE
    |=> sfr_rdata_out == $past(offset_coef[15:8]))
    else $error("offset middle readback wrong");
  offset_extreme_a: assert property (
    cal_result_in.done && !cal_result_in.is_gain &&
    (cal_result_in.value == acc_pkg::OFFSET_FS_POS ||
     cal_result_in.value == acc_pkg::OFFSET_FS_NEG) |=> converter_error_flag_out)
    else $error("offset extreme did not flag error");
  gain_extreme_a: assert property (
    cal_result_in.done && cal_result_in.is_gain &&
    (cal_result_in.value == acc_pkg::GAIN_MIN ||
     cal_result_in.value == acc_pkg::GAIN_MAX) |=> converter_error_flag_out)
    else $error("gain extreme did not flag error");
  error_cause_a: assert property (
    $rose(converter_error_flag_out) |-> $past(cal_bad))
    else $error("error flag rose without a bad calibration");
  unity_pass_a: assert property (
    conv_valid_in && offset_coef == 24'h000000 && gain_coef == acc_pkg::GAIN_RESET && !RES16
    |=> conv_valid_out && conv_data_out == $past(conv_data_in))
    else $error("unity correction altered the result");
  error_clear_a: assert property (
    err_clear_in && !cal_bad |=> !converter_error_flag_out)
    else $error("error flag not cleared");

  cal_offset_c: cover property (cal_result_in.done && !cal_result_in.is_gain);
  cal_gain_bad_c: cover property (cal_bad && cal_result_in.is_gain);
  clear_vs_set_c: cover property (cal_bad && err_clear_in);
  conv_c: cover property (conv_valid_in ##1 conv_valid_out);
endmodule

// file: acc_core_model.sv
// Core-side model that issues byte accesses to the coefficient registers
`timescale 1ns/100ps
module acc_core_model (
  input  wire logic            clk_in,
  input  wire logic [7:0]      sfr_rdata_in,
  output acc_pkg::acc_sfr_req_t sfr_req_out
);
  initial sfr_req_out = '0;
  // Idle lines carry inverted values so a stale address never looks like a request
  task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge clk_in);
    sfr_req_out = '{addr: a, wr: w, rd: !w, wdata: d};
    @(negedge clk_in);
    q = sfr_rdata_in;
    sfr_req_out = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask
endmodule

// file: tb_top.sv
// Self-checking bench for the calibration coefficient bank
`timescale 1ns/100ps
module tb_top;
  logic                     clk_in = 1'b0;
  logic                     resetn_in = 1'b0;
  acc_pkg::acc_sfr_req_t    sfr_req;
  acc_pkg::acc_cal_result_t cal = '0;
  logic                     err_clear = 1'b0;
  logic                     conv_valid = 1'b0;
  logic [23:0]              conv_data = 24'h000000;
  logic [7:0]               rdata;
  logic [7:0]               q;
  logic                     err_flag;
  logic                     valid_out;
  logic [23:0]              data_out;
  logic                     valid16;
  logic [23:0]              data16;
  int                       bad_count = 0;
  int                       n_tests = 0;
  initial forever #4 clk_in = ~clk_in;
  acc_core_model core (.clk_in(clk_in), .sfr_rdata_in(rdata), .sfr_req_out(sfr_req));
  acc_bank DUT (.clk_in(clk_in), .resetn_in(resetn_in), .sfr_req_in(sfr_req),
    .sfr_rdata_out(rdata), .cal_result_in(cal), .err_clear_in(err_clear),
    .converter_error_flag_out(err_flag), .conv_valid_in(conv_valid),
    .conv_data_in(conv_data), .conv_valid_out(valid_out), .conv_data_out(data_out));
  // Second copy as the 16-bit variant, sharing every input
  acc_bank #(.RES16(1'b1)) DUT16 (.clk_in(clk_in), .resetn_in(resetn_in), .sfr_req_in(sfr_req),
    .sfr_rdata_out(), .cal_result_in(cal), .err_clear_in(err_clear),
    .converter_error_flag_out(), .conv_valid_in(conv_valid),
    .conv_data_in(conv_data), .conv_valid_out(valid16), .conv_data_out(data16));
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    core.access(a, 1'b0, 8'h00, q);
    chk($sformatf("register %h", a), {16'h0000, exp}, {16'h0000, q});
  endtask
  task automatic put24(input logic [7:0] a, input logic [23:0] v);
    for (int i = 0; i < 3; i++) core.access(a + 8'(i), 1'b1, v[23 - 8 * i -: 8], q);
  endtask
  task automatic get24(input logic [7:0] a, input logic [23:0] v);
    for (int i = 0; i < 3; i++) rd_chk(a + 8'(i), v[23 - 8 * i -: 8]);
  endtask
  task automatic conv(input logic [23:0] din, input logic [23:0] exp, input logic [23:0] exp16);
    @(negedge clk_in);
    conv_valid = 1'b1;
    conv_data = din;
    @(negedge clk_in);
    conv_valid = 1'b0;
    chk("corrected valid", 24'h000001, {23'h000000, valid_out});
    chk("corrected data", exp, data_out);
    chk("corrected valid 16", 24'h000001, {23'h000000, valid16});
    chk("corrected data 16", exp16, data16);
  endtask
  // Flag must appear one cycle after the result, survive the readback, then clear
  task automatic calib(input logic g, input logic [23:0] v, input logic e);
    @(negedge clk_in);
    cal = '{done: 1'b1, is_gain: g, value: v};
    @(negedge clk_in);
    cal.done = 1'b0;
    chk("error flag", {23'h000000, e}, {23'h000000, err_flag});
    get24(g ? acc_pkg::ADDR_GAIN_HIGH : acc_pkg::ADDR_OFFSET_HIGH, v);
    chk("error held", {23'h000000, e}, {23'h000000, err_flag});
    err_clear = 1'b1;
    @(negedge clk_in);
    err_clear = 1'b0;
    chk("error cleared", 24'h000000, {23'h000000, err_flag});
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #(5000 * 8);
    bad_count++;
    print_verdict;
  end
  initial begin
    repeat (6) @(negedge clk_in);
    resetn_in = 1'b1;
    get24(acc_pkg::ADDR_OFFSET_HIGH, acc_pkg::OFFSET_RESET);
    get24(acc_pkg::ADDR_GAIN_HIGH, acc_pkg::GAIN_RESET);
    rd_chk(8'hC6, 8'h00);
    conv(24'h123456, 24'h123456, 24'h123400);
    $display("test reset_values done");
    put24(acc_pkg::ADDR_OFFSET_HIGH, 24'hA5C30F);
    get24(acc_pkg::ADDR_OFFSET_HIGH, 24'hA5C30F);
    put24(acc_pkg::ADDR_GAIN_HIGH, 24'h5A3CF0);
    get24(acc_pkg::ADDR_GAIN_HIGH, 24'h5A3CF0);
    $display("test register_access done");
    put24(acc_pkg::ADDR_OFFSET_HIGH, 24'h000010);
    put24(acc_pkg::ADDR_GAIN_HIGH, 24'h940000);
    conv(24'h000110, 24'h000128, 24'h000100);
    conv(24'h000000, 24'hFFFFED, 24'hFFFF00);
    $display("test correction done");
    calib(1'b0, acc_pkg::OFFSET_FS_POS, 1'b1);
    calib(1'b0, acc_pkg::OFFSET_FS_NEG, 1'b1);
    calib(1'b0, 24'h000123, 1'b0);
    calib(1'b1, acc_pkg::GAIN_MIN, 1'b1);
    calib(1'b1, acc_pkg::GAIN_MAX, 1'b1);
    calib(1'b1, 24'h940000, 1'b0);
    $display("test calibration done");
    // A bad result and a clear in one cycle: the set must win
    @(negedge clk_in);
    cal = '{done: 1'b1, is_gain: 1'b1, value: acc_pkg::GAIN_MAX};
    err_clear = 1'b1;
    @(negedge clk_in);
    cal.done = 1'b0;
    err_clear = 1'b0;
    chk("error set over clear", 24'h000001, {23'h000000, err_flag});
    $display("test error_priority done");
    print_verdict;
  end
endmodule
